/* File: rtl/ohm_consts.svh */
// Constants of the overhead message engine: octet codes, limits and time-outs.
`ifndef OHM_CONSTS_SVH
`define OHM_CONSTS_SVH
`define OHM_FLAG 8'h7e
`define OHM_ESC 8'h7d
`define OHM_XOR 8'h20
`define OHM_CRC_INIT 16'hffff
`define OHM_CRC_POLY 16'h8408
`define OHM_MAX_LEN 1024
`define OHM_PRI_RSVD 2'h3
`define OHM_CLK_KHZ 125000
`define OHM_TO1_MS 400
`define OHM_TO2_MS 800
`define OHM_TO3_MS 1000
`define OHM_TO1_CYC (`OHM_TO1_MS * `OHM_CLK_KHZ)
`define OHM_TO2_CYC (`OHM_TO2_MS * `OHM_CLK_KHZ)
`define OHM_TO3_CYC (`OHM_TO3_MS * `OHM_CLK_KHZ)
`endif

/* File: rtl/ohm_pkg.sv */
// Types and the frame check function shared by the overhead message engine.
`include "ohm_consts.svh"
package ohm_pkg;
    // Transmit sequencer states.
    typedef enum logic [2:0] {
        S_FLAG = 3'b000,
        S_ADDR = 3'b001,
        S_CTRL = 3'b010,
        S_DATA = 3'b011,
        S_FCSH = 3'b100,
        S_FCSL = 3'b101
    } ohm_txst_t;

    // Message posted by the management protocol function.
    typedef struct packed {
        logic [1:0] pri;
        logic resp;
        logic [10:0] len;
    } ohm_post_t;

    // Verdict on a received frame, shown with the end pulse.
    typedef struct packed {
        logic good;
        logic [1:0] pri;
        logic resp;
        logic seq;
        logic repeated;
    } ohm_dlv_t;

    // One octet step of the reflected 16-bit HDLC frame check.
    function automatic logic [15:0] ohm_crc(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `OHM_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : ohm_crc
endpackage : ohm_pkg

/* File: rtl/ohm_rx.sv */
// Receive deframer: flag hunt, transparency removal, frame check and field validation.
`timescale 1ns/1ps
`default_nettype none
module ohm_rx import ohm_pkg::*; (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // Incoming overhead octets.
    input wire logic rxValid,
    input wire logic [7:0] rxOctet,
    // Delivery to the management protocol function.
    output logic dlvValid,
    output logic [7:0] dlvData,
    output logic dlvEnd,
    output ohm_dlv_t dlvInfo
);
    logic hunt_r;
    logic esc_r;
    logic [10:0] cnt_r;
    logic [1:0] fill_r;
    logic [7:0] addr_r;
    logic [7:0] ctrl_r;
    logic [7:0] hold0_r;
    logic [7:0] hold1_r;
    logic [15:0] crc_r;
    logic [5:0] seen_r;
    logic [5:0] lastSeq_r;

    // Octet classification and the checks made when a flag closes a frame.
    wire step = clkEn & rxValid;
    wire isFlag = rxOctet == `OHM_FLAG;
    wire isEsc = rxOctet == `OHM_ESC;
    wire [7:0] plain = esc_r ? (rxOctet ^ `OHM_XOR) : rxOctet;
    wire closing = step & isFlag & ~hunt_r & (cnt_r != 11'h000);
    wire [2:0] slot = {addr_r[1:0], ctrl_r[1]};
    wire slotInRange = slot < 3'h6;
    wire [2:0] slotIdx = slotInRange ? slot : 3'h0;
    wire hdrOk = (addr_r[7:2] == 6'h00) & (addr_r[1:0] != `OHM_PRI_RSVD) & (ctrl_r[7:2] == 6'h00); // [R20]
    wire fcsOk = {hold0_r, hold1_r} == ~crc_r; // [R19]
    wire sizeOk = (cnt_r >= 11'h004) & (cnt_r <= 11'(`OHM_MAX_LEN + 4)); // [R24]
    wire good = closing & ~esc_r & hdrOk & fcsOk & sizeOk & (fill_r == 2'h2); // [R19]
    wire emit = step & ~hunt_r & ~isFlag & ~(isEsc & ~esc_r) & (cnt_r >= 11'h002) & (fill_r == 2'h2);

    // Framing state: a flag opens a frame, escape then flag aborts it.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hunt_r <= 1'b1;
            esc_r <= 1'b0;
            cnt_r <= 11'h000;
            fill_r <= 2'h0;
            addr_r <= 8'h00;
            ctrl_r <= 8'h00;
            hold0_r <= 8'h00;
            hold1_r <= 8'h00;
            crc_r <= `OHM_CRC_INIT;
        end else if (step) begin
            if (isFlag) begin // [R18] [R23]
                hunt_r <= 1'b0;
                esc_r <= 1'b0;
                cnt_r <= 11'h000;
                fill_r <= 2'h0;
                crc_r <= `OHM_CRC_INIT;
            end else if (!hunt_r && isEsc && !esc_r) begin
                esc_r <= 1'b1;
            end else if (!hunt_r) begin
                esc_r <= 1'b0;
                if (cnt_r != 11'h7ff) begin
                    cnt_r <= cnt_r + 11'h001;
                end
                if (cnt_r == 11'h000) begin
                    addr_r <= plain;
                    crc_r <= ohm_crc(crc_r, plain);
                end else if (cnt_r == 11'h001) begin
                    ctrl_r <= plain;
                    crc_r <= ohm_crc(crc_r, plain);
                end else begin
                    hold0_r <= hold1_r;
                    hold1_r <= plain;
                    fill_r <= (fill_r == 2'h2) ? 2'h2 : fill_r + 2'h1;
                    if (fill_r == 2'h2) begin
                        crc_r <= ohm_crc(crc_r, hold0_r);
                    end
                end
            end
        end
    end

    // Payload octets leave two octets late so the check octets never reach the user.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dlvValid <= 1'b0;
            dlvData <= 8'h00;
            dlvEnd <= 1'b0;
            dlvInfo <= '0;
        end else if (clkEn) begin
            dlvValid <= emit; // [R22]
            if (emit) begin
                dlvData <= hold0_r;
            end
            dlvEnd <= closing;
            if (closing) begin
                // A reserved priority gives a slot past the table, so it never reads as repeated.
                dlvInfo <= '{good: good, pri: addr_r[1:0], resp: ctrl_r[1], seq: ctrl_r[0],
                             repeated: slotInRange & seen_r[slotIdx] & (lastSeq_r[slotIdx] == ctrl_r[0])}; // [R21]
            end
        end
    end

    // Last accepted sequence bit per priority and message type.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            seen_r <= 6'h00;
            lastSeq_r <= 6'h00;
        end else if (clkEn && good) begin
            seen_r[slotIdx] <= 1'b1; // [R21]
            lastSeq_r[slotIdx] <= ctrl_r[0];
        end
    end
endmodule : ohm_rx
`default_nettype wire

/* File: rtl/ohm_engine.sv */
// Overhead message engine: prioritised framer with time-outs, retries and receive path.
//
// Behaviour
// [R1] Address low bits carry priority 00/01/10.
// [R2] Never send 11; upper address bits zero.
// [R3] Time-outs 400 ms, 800 ms, 1 s.
// [R4] Control bit 1: command 0, response 1.
// [R5] Other control bits above 1 are zero.
// [R6] New command inverts its sequence bit.
// [R7] New response inverts its own sequence bit.
// [R8] One outstanding command per priority.
// [R9] Time-out resends command, same sequence bit.
// [R10] Give up after configurable retry count.
// [R11] Timer runs from last octet sent.
// [R12] Append check octets, escape, flag fill.
// [R13] One flag may close and open.
// [R14] Highest pending priority is sent first.
// [R15] Abort lower frame with escape then flag.
// [R16] Finished lower message keeps its timer.
// [R17] Aborted message resent, same sequence bit.
// [R18] Receiver hunts frames on octet boundaries.
// [R19] Drop invalid frames and bad check.
// [R20] Drop frames with bad address or control.
// [R21] Sequence bit flags repeated frames.
// [R22] Deliver good frames; accept prioritised messages.
// [R23] Frame: flag, address, control, payload, check, flag.
// [R24] Payload at most 1024 octets.
// [R25] HDLC CRC-16, 7D escape, flag fill.
// [R26] Per-priority timer, sequence bit and retry count.
`timescale 1ns/1ps
`default_nettype none
module ohm_engine import ohm_pkg::*; #(
    parameter int unsigned TO1_CYC = `OHM_TO1_CYC,
    parameter int unsigned TO2_CYC = `OHM_TO2_CYC,
    parameter int unsigned TO3_CYC = `OHM_TO3_CYC,
    parameter int RETRY_W = 4,
    parameter int LEN_W = 11
) (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    // Message posting and slot occupancy.
    input wire logic postValid,
    input wire ohm_post_t postReq,
    output logic [5:0] slotBusy,
    // Payload fetch from the poster's message store.
    output logic [2:0] srcSlot,
    output logic [LEN_W-1:0] srcIdx,
    input wire logic [7:0] srcData,
    // Command outcome.
    input wire logic [RETRY_W-1:0] retryLimit,
    output logic [2:0] cmdAcked,
    output logic [2:0] cmdAbandoned,
    // Transmit overhead octets.
    input wire logic txTake,
    output logic [7:0] txOctet,
    // Receive overhead octets.
    input wire logic rxValid,
    input wire logic [7:0] rxOctet,
    // Delivery of received messages.
    output logic dlvValid,
    output logic [7:0] dlvData,
    output logic dlvEnd,
    output ohm_dlv_t dlvInfo
);
    localparam logic [26:0] TO_LOAD [3] = '{27'(TO1_CYC - 1), 27'(TO2_CYC - 1), 27'(TO3_CYC - 1)}; // [R3]

    logic [5:0] need_r;
    logic [5:0] seq_r;
    logic [LEN_W-1:0] len_r [6];
    logic [26:0] tmr_r [3];
    logic [2:0] armed_r;
    logic [RETRY_W-1:0] retry_r [3];
    ohm_txst_t st_r;
    logic [2:0] cur_r;
    logic escPend_r;
    logic [7:0] escByte_r;
    logic [15:0] crc_r;

    // Lowest slot index wins: priority 0 first, and a command ahead of a response of its level.
    function automatic logic [3:0] pick_slot(input logic [5:0] pend);
        logic [3:0] r;
        r = 4'h0;
        for (int s = 5; s >= 0; s--) begin
            if (pend[s]) begin
                r = {1'b1, 3'(s)};
            end
        end
        return r;
    endfunction : pick_slot

    // Selection of the next frame and pre-emption of the one on the line.
    wire [3:0] pickRes = pick_slot(need_r); // [R14]
    wire pickOk = pickRes[3];
    wire [2:0] pickSlot = pickRes[2:0];
    wire inFrame = st_r != S_FLAG;
    wire step = clkEn & txTake;
    wire preempt = inFrame & pickOk & (pickSlot[2:1] < cur_r[2:1]); // [R14]
    wire contentStep = step & ~escPend_r & ~preempt;

    // Octet content of each field, escaped when it looks like a flag or escape.
    wire [7:0] addrOct = {6'h00, cur_r[2:1]}; // [R1] [R2]
    wire [7:0] ctrlOct = {6'h00, cur_r[0], seq_r[cur_r]}; // [R4] [R5]
    wire [7:0] rawOct = (st_r == S_ADDR) ? addrOct :
                        (st_r == S_CTRL) ? ctrlOct :
                        (st_r == S_DATA) ? srcData :
                        (st_r == S_FCSH) ? ~crc_r[15:8] : ~crc_r[7:0]; // [R12] [R25]
    wire needEsc = (rawOct == `OHM_FLAG) | (rawOct == `OHM_ESC); // [R12] [R25]
    wire emptyMsg = len_r[cur_r] == '0;
    wire lastData = srcIdx == LEN_W'(len_r[cur_r] - 1'b1);
    wire isFcs = (st_r == S_FCSH) | (st_r == S_FCSL);
    wire ohm_txst_t stNext = (st_r == S_ADDR) ? S_CTRL :
                             (st_r == S_CTRL) ? (emptyMsg ? S_FCSH : S_DATA) :
                             (st_r == S_DATA) ? (lastData ? S_FCSH : S_DATA) :
                             (st_r == S_FCSH) ? S_FCSL : S_FLAG; // [R23]
    wire frameEnd = contentStep & (st_r == S_FCSL);

    // Per-slot and per-priority events.
    wire [2:0] postSlot = {postReq.pri, postReq.resp};
    wire postOk = clkEn & postValid & (postReq.pri != `OHM_PRI_RSVD) &
                  (postReq.len <= 11'(`OHM_MAX_LEN)); // [R2] [R24]
    wire respIn = clkEn & dlvEnd & dlvInfo.good & dlvInfo.resp;
    logic [5:0] postHit;
    logic [5:0] sentDone;
    logic [2:0] ackHit;
    logic [2:0] expire;
    logic [2:0] giveUp;
    logic [5:0] endSlot;
    logic [5:0] resendSlot;

    // Decode of the events that move the slot state.
    always_comb begin
        for (int s = 0; s < 6; s++) begin
            postHit[s] = postOk & (postSlot == 3'(s)) & ~slotBusy[s]; // [R8] [R22]
            sentDone[s] = frameEnd & (cur_r == 3'(s));
        end
        for (int p = 0; p < 3; p++) begin
            ackHit[p] = respIn & (dlvInfo.pri == 2'(p)) & slotBusy[2*p]; // [R8]
            expire[p] = clkEn & armed_r[p] & (tmr_r[p] == 27'h0000000) & ~ackHit[p];
            giveUp[p] = expire[p] & (retry_r[p] == retryLimit); // [R10]
        end
        for (int s = 0; s < 6; s++) begin
            endSlot[s] = s[0] ? sentDone[s] : (ackHit[s/2] | giveUp[s/2]);
            resendSlot[s] = s[0] ? 1'b0 : (expire[s/2] & ~giveUp[s/2]); // [R9]
        end
    end

    // Slot occupancy, pending-send flags, sequence bits and lengths.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            slotBusy <= 6'h00;
            need_r <= 6'h00;
            seq_r <= 6'h00;
            for (int s = 0; s < 6; s++) begin
                len_r[s] <= '0;
            end
        end else if (clkEn) begin
            slotBusy <= (slotBusy & ~endSlot) | postHit; // [R8]
            need_r <= (need_r & ~sentDone & ~endSlot) | postHit | resendSlot; // [R9] [R16] [R17]
            seq_r <= seq_r ^ postHit; // [R6] [R7] [R26]
            for (int s = 0; s < 6; s++) begin
                if (postHit[s]) begin
                    len_r[s] <= LEN_W'(postReq.len);
                end
            end
        end
    end

    // Per-priority response timers and retry counts.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            armed_r <= 3'h0;
            cmdAcked <= 3'h0;
            cmdAbandoned <= 3'h0;
            for (int p = 0; p < 3; p++) begin
                tmr_r[p] <= 27'h0000000;
                retry_r[p] <= '0;
            end
        end else if (clkEn) begin
            cmdAcked <= ackHit;
            cmdAbandoned <= giveUp; // [R10]
            for (int p = 0; p < 3; p++) begin
                if (sentDone[2*p] && slotBusy[2*p] && !ackHit[p]) begin
                    armed_r[p] <= 1'b1; // [R11]
                    tmr_r[p] <= TO_LOAD[p]; // [R3] [R26]
                end else if (ackHit[p] || expire[p]) begin
                    armed_r[p] <= 1'b0;
                end else if (armed_r[p]) begin
                    tmr_r[p] <= tmr_r[p] - 27'h0000001; // [R16]
                end
                if (postHit[2*p]) begin
                    retry_r[p] <= '0;
                end else if (resendSlot[2*p]) begin
                    retry_r[p] <= retry_r[p] + 1'b1; // [R26]
                end
            end
        end
    end

    // Transmit sequencer: flag fill, fields, escapes and aborts.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= S_FLAG;
            cur_r <= 3'h0;
            escPend_r <= 1'b0;
            escByte_r <= 8'h00;
            crc_r <= `OHM_CRC_INIT;
            txOctet <= `OHM_FLAG;
            srcSlot <= 3'h0;
            srcIdx <= '0;
        end else if (step) begin
            if (escPend_r) begin
                txOctet <= escByte_r ^ `OHM_XOR; // [R12]
                escPend_r <= 1'b0;
            end else if (preempt) begin
                txOctet <= `OHM_ESC; // [R15]
                st_r <= S_FLAG; // [R17]
            end else if (!inFrame) begin
                txOctet <= `OHM_FLAG; // [R12] [R13]
                if (pickOk) begin
                    cur_r <= pickSlot;
                    srcSlot <= pickSlot;
                    srcIdx <= '0;
                    crc_r <= `OHM_CRC_INIT;
                    st_r <= S_ADDR;
                end
            end else begin
                txOctet <= needEsc ? `OHM_ESC : rawOct;
                escPend_r <= needEsc;
                escByte_r <= rawOct;
                crc_r <= isFcs ? crc_r : ohm_crc(crc_r, rawOct); // [R12] [R25]
                st_r <= stNext;
                if (st_r == S_DATA) begin
                    srcIdx <= srcIdx + 1'b1;
                end
            end
        end
    end

    // Receive path.
    ohm_rx uRx (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clkEn(clkEn),
        .rxValid(rxValid),
        .rxOctet(rxOctet),
        .dlvValid(dlvValid),
        .dlvData(dlvData),
        .dlvEnd(dlvEnd),
        .dlvInfo(dlvInfo)
    );
endmodule : ohm_engine
`default_nettype wire

/* File: dv/ohm_engine_checker.sv */
// Port checker of the overhead message engine, bound to every engine instance.
`timescale 1ns/1ps
`default_nettype none
module ohm_engine_checker import ohm_pkg::*; (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Observed ports.
    input wire logic clkEn,
    input wire logic postValid,
    input wire ohm_post_t postReq,
    input wire logic [5:0] slotBusy,
    input wire logic [2:0] cmdAcked,
    input wire logic [2:0] cmdAbandoned,
    input wire logic txTake,
    input wire logic [7:0] txOctet,
    input wire logic rxValid,
    input wire logic dlvValid,
    input wire logic dlvEnd,
    input wire ohm_dlv_t dlvInfo
);
    // All checks run on the system clock and rest while reset is low.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_tx_octet_holds: assert property (clkEn && !txTake |=> $stable(txOctet))
        else $error("Octet moved without a take.");
    a_escape_then_ok: assert property (clkEn && txTake && txOctet == 8'h7d |=> txOctet inside {8'h5d, 8'h5e, 8'h7e})
        else $error("Bad octet after escape.");
    a_ack_needs_resp: assert property (cmdAcked[0] |-> $past(dlvEnd && dlvInfo.good && dlvInfo.resp && dlvInfo.pri == 2'h0))
        else $error("Ack without a good response.");
    a_ack_one_cycle: assert property (cmdAcked != 3'h0 |=> cmdAcked == 3'h0)
        else $error("Ack pulse too long.");
    a_end_one_cycle: assert property (dlvEnd |=> !dlvEnd)
        else $error("End pulse too long.");
    a_dlv_after_rx: assert property (dlvValid || dlvEnd |-> $past(clkEn && rxValid))
        else $error("Delivery without a line octet.");
    a_post_opens_slot: assert property ($rose(slotBusy[0]) |-> $past(clkEn && postValid && postReq.pri == 2'h0 && !postReq.resp))
        else $error("Slot taken without a post.");
    a_slot_free_cause: assert property ($fell(slotBusy[0]) |-> $past(cmdAcked[0] || cmdAbandoned[0]) or ##[0:1] (cmdAcked[0] || cmdAbandoned[0]))
        else $error("Command slot freed without cause.");
endmodule : ohm_engine_checker
bind ohm_engine ohm_engine_checker chk (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .postValid(postValid),
    .postReq(postReq), .slotBusy(slotBusy), .cmdAcked(cmdAcked), .cmdAbandoned(cmdAbandoned), .txTake(txTake),
    .txOctet(txOctet), .rxValid(rxValid), .dlvValid(dlvValid), .dlvEnd(dlvEnd), .dlvInfo(dlvInfo));
`default_nettype wire

/* File: dv/ohm_peer.sv */
// Peer line model: consumes and checks sent frames, builds received frames.
`timescale 1ns/1ps
`default_nettype none
module ohm_peer (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Line towards the engine.
    input wire logic slow,
    input wire logic [7:0] txOctet,
    output logic txTake,
    output logic rxValid,
    output logic [7:0] rxOctet
);
    logic [7:0] bq[$];
    logic [27:0] frm[$];
    logic esc;
    logic [1:0] phase;
    int nAbort;
    // Reflected frame check step, kept apart from the engine's own.
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ({1'b0, c[15:1]} ^ 16'h8408) : {1'b0, c[15:1]};
        end
        return c;
    endfunction : crcStep
    // Records fields, length and integrity of a closed frame.
    task automatic closeFrame();
        logic [15:0] c;
        logic ok;
        int n;
        n = bq.size();
        c = 16'hffff;
        ok = 1;
        for (int k = 0; k < n - 2; k++) begin
            c = crcStep(c, bq[k]);
            if (k > 1 && bq[k] !== ({bq[0][1:0], bq[1][1], 5'(k - 2)} ^ 8'h7c)) ok = 0;
        end
        ok = ok && (~c === {bq[n-2], bq[n-1]});
        frm.push_back({ok, 11'(n - 4), bq[0], bq[1]});
    endtask : closeFrame
    // Drives one octet, escaped when it is a flag or escape octet inside a frame body.
    task automatic sendByte(input logic [7:0] b, input logic body);
        if (body && (b == 8'h7e || b == 8'h7d)) begin
            @(posedge clk_sys);
            rxValid <= 1;
            rxOctet <= 8'h7d;
            b = b ^ 8'h20;
        end
        @(posedge clk_sys);
        rxValid <= 1;
        rxOctet <= b;
    endtask : sendByte
    // Sends a whole frame; bad flips bit 0 of the second check octet.
    task automatic sendFrame(input logic [7:0] a, input logic [7:0] c, input int n, input logic bad);
        logic [7:0] f[$];
        logic [15:0] crc;
        f = {a, c};
        for (int k = 0; k < n; k++) f.push_back(8'h7e - 8'(k));
        crc = 16'hffff;
        foreach (f[k]) crc = crcStep(crc, f[k]);
        crc = ~crc ^ {15'h0, bad};
        f.push_back(crc[15:8]);
        f.push_back(crc[7:0]);
        sendByte(8'h7e, 0);
        foreach (f[k]) sendByte(f[k], 1);
        sendByte(8'h7e, 0);
        @(posedge clk_sys);
        rxValid <= 0;
        rxOctet <= 8'h81;
    endtask : sendFrame
    // Starting values at time zero.
    initial begin
        txTake = 0;
        rxValid = 0;
        rxOctet = 8'h00;
        esc = 0;
        phase = 0;
        nAbort = 0;
    end
    // Hunts flags on taken octets, removes escapes, counts aborts.
    always @(posedge clk_sys) begin
        if (nrst && txTake) begin
            if (txOctet == 8'h7e) begin
                if (esc) nAbort++;
                else if (bq.size() >= 4) closeFrame();
                bq.delete();
                esc = 0;
            end else if (txOctet == 8'h7d) begin
                esc = 1;
            end else begin
                bq.push_back(esc ? txOctet ^ 8'h20 : txOctet);
                esc = 0;
            end
        end
        phase <= phase + 2'h1;
        txTake <= nrst && (!slow || phase == 2'h3);
    end
endmodule : ohm_peer
`default_nettype wire

/* File: dv/test_ohm_engine.sv */
// Self-checking bench of the overhead message engine.
`timescale 1ns/1ps
`default_nettype none
module test_ohm_engine;
    import ohm_pkg::*;
    typedef struct packed {
        logic [1:0] pri;
        logic resp;
        logic [10:0] len;
        logic seq;
    } ohm_row_t;
    localparam int TO1 = 300;
    logic clk_sys, nrst, clkEn, postValid, txTake, rxValid, dlvValid, dlvEnd, slow;
    logic [7:0] txOctet, rxOctet, srcData, dlvData;
    logic [5:0] slotBusy;
    logic [2:0] srcSlot, cmdAcked, cmdAbandoned;
    logic [10:0] srcIdx;
    logic [3:0] retryLimit;
    logic [27:0] f, g;
    logic [7:0] rxq[$];
    ohm_post_t postReq;
    ohm_dlv_t dlvInfo;
    int n_fail, checked, cyc, a;
    int nAck[3];
    int nAbn[3];
    ohm_row_t rows[8] = '{{2'h0, 1'b1, 11'd3, 1'b1}, {2'h0, 1'b1, 11'd0, 1'b0}, {2'h1, 1'b1, 11'd5, 1'b1},
        {2'h2, 1'b1, 11'd2, 1'b1}, {2'h0, 1'b0, 11'd3, 1'b1}, {2'h0, 1'b0, 11'd1, 1'b0},
        {2'h1, 1'b0, 11'd4, 1'b1}, {2'h2, 1'b0, 11'd1024, 1'b1}};
    ohm_engine #(.TO1_CYC(TO1), .TO2_CYC(400), .TO3_CYC(500)) uut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
        .postValid(postValid), .postReq(postReq), .slotBusy(slotBusy), .srcSlot(srcSlot), .srcIdx(srcIdx),
        .srcData(srcData), .retryLimit(retryLimit), .cmdAcked(cmdAcked), .cmdAbandoned(cmdAbandoned),
        .txTake(txTake), .txOctet(txOctet), .rxValid(rxValid), .rxOctet(rxOctet), .dlvValid(dlvValid),
        .dlvData(dlvData), .dlvEnd(dlvEnd), .dlvInfo(dlvInfo));
    ohm_peer peer (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .txOctet(txOctet), .txTake(txTake),
        .rxValid(rxValid), .rxOctet(rxOctet));
    // Message store: each payload octet follows from its slot and index.
    assign srcData = {srcSlot, srcIdx[4:0]} ^ 8'h7c;
    // Counts cycles and outcome pulses, gathers delivered octets.
    always @(posedge clk_sys) begin
        cyc++;
        for (int p = 0; p < 3; p++) begin
            nAck[p] += cmdAcked[p];
            nAbn[p] += cmdAbandoned[p];
        end
        if (dlvValid) rxq.push_back(dlvData);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic post(input logic [1:0] p, input logic r, input logic [10:0] n);
        @(posedge clk_sys);
        postValid <= 1;
        postReq <= {p, r, n};
        @(posedge clk_sys);
        postValid <= 0;
    endtask : post
    task automatic waitFrame(output logic [27:0] w);
        for (int i = 0; i < 3000 && peer.frm.size() == 0; i++) @(posedge clk_sys);
        w = (peer.frm.size() > 0) ? peer.frm.pop_front() : 28'h0;
    endtask : waitFrame
    // Answers an outstanding command and expects its slot to free.
    task automatic ackCmd(input logic [1:0] p, input logic s);
        int b;
        b = nAck[p];
        peer.sendFrame({6'h0, p}, {6'h0, 1'b1, s}, 2, 1'b0);
        repeat (4) @(posedge clk_sys);
        check(nAck[p] - b, 1);
        check({dlvInfo.good, dlvInfo.pri, dlvInfo.resp}, {1'b1, p, 1'b1});
        check(slotBusy[{p, 1'b0}], 1'b0);
    endtask : ackCmd
    task automatic rxCase(input logic [7:0] ad, input logic [7:0] ct, input logic bad);
        peer.sendFrame(ad, ct, 3, bad);
        repeat (2) @(posedge clk_sys);
    endtask : rxCase
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    initial begin
        nrst = 0;
        clkEn = 1;
        postValid = 0;
        postReq = '0;
        retryLimit = 4'h1;
        slow = 0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1;
        @(posedge clk_sys);
        check(txOctet, 8'h7e);
        check(slotBusy, 6'h0);
        for (int i = 0; i < 8; i++) begin
            post(rows[i].pri, rows[i].resp, rows[i].len);
            waitFrame(f);
            check(f, {1'b1, rows[i].len, 6'h0, rows[i].pri, 6'h0, rows[i].resp, rows[i].seq});
            if (!rows[i].resp) ackCmd(rows[i].pri, rows[i].seq);
            $display("Row %0d done", i);
        end
        a = nAbn[0];
        post(2'h0, 1'b0, 11'd1);
        waitFrame(f);
        a = a + 0;
        check(f[0], 1'b1);
        begin
            int t0;
            t0 = cyc;
            waitFrame(g);
            check(g, f);
            check((cyc - t0) >= TO1 && (cyc - t0) <= TO1 + 20, 1);
        end
        repeat (TO1 + 20) @(posedge clk_sys);
        check(nAbn[0] - a, 1);
        check(slotBusy[0], 1'b0);
        $display("Time-out test done");
        slow <= 1;
        post(2'h2, 1'b0, 11'd40);
        repeat (40) @(posedge clk_sys);
        a = peer.nAbort;
        post(2'h0, 1'b1, 11'd1);
        waitFrame(f);
        check(f, {1'b1, 11'd1, 8'h00, 8'h03});
        check(peer.nAbort - a, 1);
        waitFrame(g);
        check(g, {1'b1, 11'd40, 8'h02, 8'h00});
        slow <= 0;
        ackCmd(2'h2, 1'b0);
        post(2'h3, 1'b0, 11'd1);
        post(2'h1, 1'b0, 11'd1025);
        repeat (2) @(posedge clk_sys);
        check(slotBusy, 6'h0);
        clkEn <= 0;
        post(2'h0, 1'b1, 11'd1);
        repeat (2) @(posedge clk_sys);
        check(slotBusy, 6'h0);
        check(txOctet, 8'h7e);
        clkEn <= 1;
        $display("Priority test done");
        rxq.delete();
        rxCase(8'h01, 8'h00, 1'b0);
        check(dlvInfo[5:1], 5'b10100);
        check({rxq[0], rxq[1], rxq[2]}, 24'h7e7d7c);
        rxCase(8'h01, 8'h00, 1'b0);
        check(dlvInfo.repeated, 1'b1);
        rxCase(8'h01, 8'h01, 1'b1);
        check(dlvInfo.good, 1'b0);
        rxCase(8'h03, 8'h00, 1'b0);
        check(dlvInfo.good, 1'b0);
        rxCase(8'h41, 8'h00, 1'b0);
        check(dlvInfo.good, 1'b0);
        rxCase(8'h01, 8'h04, 1'b0);
        check(dlvInfo.good, 1'b0);
        $display("Receive test done");
        print_verdict();
    end
endmodule : test_ohm_engine
`default_nettype wire
